// File: dv/kme_encoder_properties.sv
// output timing checker for the keypad matrix encoder
`timescale 1ns/1ps
`include "kme_regs.vh"
module kme_encoder_checker #(
    parameter [23:0] INT_CYCLES  = `KME_INT_CYC,
    parameter [23:0] LEAD_CYCLES = `KME_LEAD_CYC,
    parameter [23:0] BAUD_CYCLES = `KME_BAUD_CYC
) (
    input wire                   clk_sys,
    input wire                   reset,
    input wire [7:0]             column_sense_lines,
    input wire [7:0]             row_drive_lines_o,
    input wire [7:0]             row_drive_lines_oe,
    input wire [`KME_CODE_W-1:0] key_code_parallel_out,
    input wire                   serial_tx,
    input wire                   key_int_n,
    input wire                   led_on
);
    reg  [23:0] lo_cnt_r;
    reg  [7:0]  oe_prev_r;
    wire [23:0] frm_off = lo_cnt_r - LEAD_CYCLES;
    wire [23:0] bit_idx = frm_off / BAUD_CYCLES;
    wire        mid     = (frm_off % BAUD_CYCLES) == (BAUD_CYCLES / 2);
    wire [9:0]  frame   = {1'b1, 2'b00, key_code_parallel_out, 1'b0};
    // cycles since the interrupt fell
    always @(posedge clk_sys) begin
        lo_cnt_r  <= (reset || key_int_n) ? 24'h000000 : lo_cnt_r + 24'h000001;
        oe_prev_r <= row_drive_lines_oe;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_int_fall;
        $fell(key_int_n) && led_on;
    endsequence
    property p_pop;
        $changed(key_code_parallel_out) |=> s_int_fall;
    endproperty
    a_led_follows_int: assert property (led_on == !key_int_n)
        else $error("led drive differs from interrupt");
    a_row_onehot: assert property ($onehot(row_drive_lines_oe) && row_drive_lines_o == 8'h00)
        else $error("row drive not one open drain low");
    a_row_order: assert property ($changed(row_drive_lines_oe) |->
        row_drive_lines_oe == {oe_prev_r[6:0], oe_prev_r[7]})
        else $error("row scan out of order");
    a_tx_idle_high: assert property (key_int_n |-> serial_tx)
        else $error("serial active outside interrupt");
    a_lead_time: assert property (!key_int_n && lo_cnt_r <= LEAD_CYCLES |->
        serial_tx == (lo_cnt_r != LEAD_CYCLES))
        else $error("start bit lead wrong");
    a_frame_bits: assert property (!key_int_n && lo_cnt_r >= LEAD_CYCLES && mid
        && bit_idx < 24'h00000A |-> serial_tx == frame[bit_idx])
        else $error("serial frame bit wrong");
    a_int_width: assert property ($rose(key_int_n) |->
        lo_cnt_r == LEAD_CYCLES + 10 * BAUD_CYCLES + INT_CYCLES)
        else $error("interrupt width wrong");
    a_par_steady: assert property (!key_int_n |-> $stable(key_code_parallel_out))
        else $error("parallel code moved during interrupt");
    a_par_then_int: assert property (p_pop)
        else $error("parallel change without interrupt");
endmodule // kme_encoder_checker

bind kme_encoder kme_encoder_checker #(
    .INT_CYCLES(INT_CYCLES), .LEAD_CYCLES(LEAD_CYCLES), .BAUD_CYCLES(BAUD_CYCLES)
) u_chk (.clk_sys(clk_sys), .reset(reset), .column_sense_lines(column_sense_lines),
    .row_drive_lines_o(row_drive_lines_o), .row_drive_lines_oe(row_drive_lines_oe),
    .key_code_parallel_out(key_code_parallel_out), .serial_tx(serial_tx),
    .key_int_n(key_int_n), .led_on(led_on));

// File: dv/kme_encoder_tb.sv
// self-checking bench for the keypad matrix encoder
`timescale 1ns/1ps
module kme_encoder_tb;
    reg        clk_sys = 1'b0;
    reg        reset = 1'b1;
    reg [63:0] keys_r = 64'h0;
    reg [15:0] lfsr_r = 16'h6126;
    reg [7:0]  col_w;
    wire [7:0] row_o, row_oe, rx_byte;
    wire [5:0] par, rx_par;
    wire       tx, int_n, led, rx_ok;
    int        rx_cnt;
    int        n_fail = 0;
    int        tests_run = 0;

    // lead and bit period keep their real values; repeat period outlasts one frame
    kme_encoder #(.MS_CYCLES(24'h0000A0), .INT_CYCLES(24'h0000C8), .DEB_SCANS(6'h03),
        .TYPE_MS(10'h018), .REP_MS(10'h010)
    ) uut (.clk_sys(clk_sys), .reset(reset), .column_sense_lines(col_w),
        .row_drive_lines_o(row_o), .row_drive_lines_oe(row_oe), .key_code_parallel_out(par),
        .serial_tx(tx), .key_int_n(int_n), .led_on(led));
    kme_host_model u_host (.clk_sys(clk_sys), .reset(reset), .serial_tx(tx),
        .key_int_n(int_n), .key_code_parallel_out(par), .rx_byte(rx_byte), .rx_par(rx_par),
        .rx_ok(rx_ok), .rx_cnt(rx_cnt));

    ////////////////////////////////////////////////////////////////////////////
    // key matrix: a closed key pulls its column low while its row is driven low
    always_comb begin
        col_w = 8'hFF;
        for (int i = 0; i < 64; i++)
            if (keys_r[i] && row_oe[i / 8] && !row_o[i / 8]) col_w[i % 8] = 1'b0;
    end
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////
    function [15:0] lfsr_next(input [15:0] x);
        lfsr_next = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function [5:0] key_code(input [2:0] r, input [2:0] c);
        key_code = {r, c};
    endfunction
    task chk(input string what, input [15:0] exp, input [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task wait_rx(input int n);
        for (int k = 0; k < 3000 && rx_cnt < n; k++) @(posedge clk_sys);
        chk("frames", n, rx_cnt);
    endtask
    task idle;
        for (int k = 0; k < 400 && int_n !== 1'b1; k++) @(posedge clk_sys);
        cyc(2);
    endtask
    task key_once(input [2:0] r, input [2:0] c);
        int n0;
        n0 = rx_cnt;
        keys_r <= 64'h1 << key_code(r, c);
        cyc(240);
        chk("early code", 16'h0001, int_n);
        wait_rx(n0 + 1);
        chk("serial byte", {2'b00, key_code(r, c)}, rx_byte);
        chk("par at int", key_code(r, c), rx_par);
        chk("frame ok", 16'h0001, rx_ok);
        keys_r <= 64'h0;
        idle();
        chk("par held", key_code(r, c), par);
        chk("led off", 16'h0000, led);
    endtask
    task finish_test;
        $display("counts: %0d checks, %0d mismatches", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(70000);
        n_fail++;
        $display("wrong value watchdog expected done seen timeout");
        finish_test();
    end
    initial begin
        int n0;
        cyc(10);
        reset <= 1'b0;
        cyc(5);
        chk("idle outs", 16'h0103, {row_oe, par, tx, int_n});
        $display("test reset done");
        key_once(3'h0, 3'h0);
        key_once(3'h4, 3'h3);
        for (int i = 0; i < 5; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            key_once(lfsr_r[5:3], lfsr_r[2:0]);
        end
        $display("test codes done");
        n0 = rx_cnt;
        // closed spans shorter than one scan, open spans longer, so no count builds up
        for (int i = 0; i < 6; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            keys_r[6'h2A] <= ~keys_r[6'h2A];
            cyc(keys_r[6'h2A] ? 170 : 20 + lfsr_r[6:0]);
        end
        chk("bounce codes", n0, rx_cnt);
        chk("bounce int", 16'h0001, int_n);
        key_once(3'h5, 3'h2);
        $display("test bounce done");
        for (int k = 0; k < 200 && row_oe !== 8'h01; k++) @(posedge clk_sys);
        n0 = rx_cnt;
        keys_r <= (64'h1 << 6'h12) | (64'h1 << 6'h35);
        wait_rx(n0 + 1);
        chk("first wins", 16'h0012, rx_byte);
        cyc(600);
        chk("locked out", n0 + 1, rx_cnt);
        chk("locked int", 16'h0001, int_n);
        keys_r <= 64'h1 << 6'h35;
        wait_rx(n0 + 2);
        chk("next in scan", 16'h0035, rx_byte);
        keys_r <= 64'h0;
        idle();
        $display("test lockout done");
        n0 = rx_cnt;
        keys_r <= 64'h1 << 6'h3F;
        wait_rx(n0 + 1);
        chk("top code", 16'h003F, rx_byte);
        cyc(4500);
        chk("first repeat", n0 + 2, rx_cnt);
        cyc(4500);
        chk("repeat rate", n0 + 4, rx_cnt);
        keys_r <= 64'h0;
        cyc(2700);
        chk("stop on release", n0 + 4, rx_cnt);
        $display("test typematic done");
        n0 = rx_cnt;
        keys_r <= 64'h1 << 6'h07;
        for (int k = 0; k < 1000 && int_n !== 1'b0; k++) @(posedge clk_sys);
        reset <= 1'b1;
        cyc(300);
        chk("reset outs", 16'h0103, {row_oe, par, tx, int_n});
        reset <= 1'b0;
        wait_rx(n0 + 1);
        chk("after reset", 16'h0007, rx_byte);
        keys_r <= 64'h0;
        idle();
        $display("test mid reset done");
        finish_test();
    end
endmodule // kme_encoder_tb

// File: dv/kme_host_model.sv
// host receiver model: uart byte and parallel code latched at start bit
`timescale 1ns/1ps
`include "kme_regs.vh"
module kme_host_model #(
    parameter BAUD = `KME_BAUD_CYC
) (
    input wire       clk_sys,
    input wire       reset,
    input wire       serial_tx,
    input wire       key_int_n,
    input wire [5:0] key_code_parallel_out,
    output reg [7:0] rx_byte,
    output reg [5:0] rx_par,
    output reg       rx_ok,
    output int       rx_cnt
);
    reg ok;
    initial begin
        rx_cnt = 0;
        rx_byte = 8'h00;
        rx_par = 6'h00;
        rx_ok = 1'b0;
        forever begin
            @(negedge clk_sys);
            if (!reset && serial_tx === 1'b0) begin
                ok = !key_int_n;
                rx_par = key_code_parallel_out;
                repeat (BAUD / 2) @(negedge clk_sys);
                for (int i = 0; i < 8; i++) begin
                    repeat (BAUD) @(negedge clk_sys);
                    rx_byte[i] = serial_tx;
                end
                repeat (BAUD) @(negedge clk_sys);
                rx_ok = ok && serial_tx && !key_int_n;
                rx_cnt++;
            end
        end
    end
endmodule // kme_host_model

// File: shared/kme_regs.vh
// timing and layout constants for the keypad matrix encoder
`ifndef KME_REGS_VH
`define KME_REGS_VH

// system clock rate in hertz
`define KME_CLK_HZ          10000000
// serial rate in baud
`define KME_BAUD            57600
// intervals in their own units
`define KME_DEB_MS          50
`define KME_STABLE_MS       20
`define KME_LEAD_US         50
`define KME_INT_MS          8
`define KME_TYPE_MS         600
`define KME_REP_MS          200
// derived cycle counts (lead rounds up, bit period rounds to nearest)
`define KME_MS_CYC          (`KME_CLK_HZ / 1000)
`define KME_LEAD_CYC        ((`KME_LEAD_US * `KME_CLK_HZ + 999999) / 1000000)
`define KME_BAUD_CYC        ((`KME_CLK_HZ + `KME_BAUD / 2) / `KME_BAUD)
`define KME_INT_CYC         (`KME_INT_MS * `KME_MS_CYC)
// matrix and frame layout
`define KME_ROWS            8
`define KME_CODE_W          6
`define KME_FRAME_BITS      4'hA
`define KME_ROW_LAST        3'h7
`define KME_COL_LAST        3'h7
`define KME_SAMPLE_BACK     24'h00000A
`define KME_FIFO_DEPTH      4
// reset values
`define KME_LINE_IDLE       1'b1
`define KME_CODE_RST        6'h00

`endif

// File: src/kme_encoder.v
// keypad matrix encoder: scanner, per-key debounce, lockout, typematic, output fifo, serial
//
// Contract
// - after reset, scanning and debouncing of all 64 keys starts by itself.
// - rows driven low one at a time by open drain; columns sensed in turn.
// - a key is accepted only after reading low continuously for about 50 ms.
// - each of the 64 switches has its own debounce counter.
// - a switch counts as stable after 20 ms without bounce, then coded; the code has no 20 ms stage and codes a key once its 50-scan count is reached.
// - first key to finish debounce wins, blocks others, emits one code.
// - each accepted key gives serial code, parallel code and one interrupt pulse.
// - no other codes while winner stays closed; lockout ends on its release.
// - after release, next still-pressed key in scan order gives the next code.
// - codes run 0x00 to 0x3F; row 4 column 3 gives 0x23.
// - interrupt falls about 50 us before the serial start bit.
// - interrupt stays low another 8 ms after the serial frame.
// - key held 600 ms repeats its code every 200 ms until release.
// - serial frame at 57.6 kbaud, one start, eight data, no parity, one stop.
// - only low six data bits carry code, top two zero, LSB first.
// - parallel code is stable before the interrupt pulse falls.
// - parallel code holds after the pulse until the next code.
// - LED drive is on for exactly the interrupt pulse interval.
`timescale 1ns/1ps
`include "kme_regs.vh"

////////////////////////////////////////////////////////////////////////////////
module kme_fifo #(
    parameter WIDTH = `KME_CODE_W,
    parameter DEPTH = `KME_FIFO_DEPTH,
    parameter AW    = 2
) (
    // clock and reset
    input  wire             clk_sys,
    input  wire             reset,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_r;
    reg [AW-1:0]    rd_ptr_r;
    reg [AW:0]      count_r;
    wire            do_wr;
    wire            do_rd;

    assign in_ready  = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data  = mem_r[rd_ptr_r];
    assign do_wr     = in_valid & in_ready;
    assign do_rd     = out_valid & out_ready;

    always @(posedge clk_sys) begin
        if (do_wr) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count_r <= count_r + 1'b1;
            end else if (do_rd && !do_wr) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule // kme_fifo

////////////////////////////////////////////////////////////////////////////////
module kme_encoder #(
    parameter [23:0] MS_CYCLES   = `KME_MS_CYC,
    parameter [23:0] INT_CYCLES  = `KME_INT_CYC,
    parameter [23:0] LEAD_CYCLES = `KME_LEAD_CYC,
    parameter [23:0] BAUD_CYCLES = `KME_BAUD_CYC,
    parameter [5:0]  DEB_SCANS   = `KME_DEB_MS,
    parameter [9:0]  TYPE_MS     = `KME_TYPE_MS,
    parameter [9:0]  REP_MS      = `KME_REP_MS
) (
    // clock and reset
    input  wire                   clk_sys,
    input  wire                   reset,
    // key matrix
    input  wire [7:0]             column_sense_lines,
    output reg  [7:0]             row_drive_lines_o,
    output reg  [7:0]             row_drive_lines_oe,
    // host side
    output reg  [`KME_CODE_W-1:0] key_code_parallel_out,
    output reg                    serial_tx,
    output reg                    key_int_n,
    output reg                    led_on
);
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_PREP = 5'h02;
    localparam [4:0] ST_LEAD = 5'h04;
    localparam [4:0] ST_SEND = 5'h08;
    localparam [4:0] ST_HOLD = 5'h10;

    // one scan of all rows takes one millisecond
    localparam [23:0] DWELL  = MS_CYCLES >> 3;
    localparam [23:0] SAMPLE = DWELL - `KME_SAMPLE_BACK;

    function [7:0] row_select;
        input [2:0] idx;
        begin
            row_select = 8'h01 << idx;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // scanner
    reg  [23:0] dwell_r;
    reg  [2:0]  row_r;
    reg  [7:0]  col_s1_r;
    reg  [7:0]  col_s2_r;
    reg         chk_r;
    reg  [2:0]  col_r;
    wire        sample_now;
    wire        row_end;
    wire        ms_tick;

    assign sample_now = (dwell_r == SAMPLE);
    assign row_end    = (dwell_r == DWELL - 24'h000001);
    assign ms_tick    = row_end & (row_r == `KME_ROW_LAST);

    always @(posedge clk_sys) begin
        col_s1_r <= column_sense_lines;
        col_s2_r <= col_s1_r;
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            dwell_r            <= 24'h000000;
            row_r              <= 3'h0;
            row_drive_lines_o  <= 8'h00;
            row_drive_lines_oe <= row_select(3'h0);
            chk_r              <= 1'b0;
            col_r              <= 3'h0;
        end else begin
            row_drive_lines_o <= 8'h00;
            if (row_end) begin
                dwell_r            <= 24'h000000;
                row_r              <= row_r + 3'h1;
                row_drive_lines_oe <= row_select(row_r + 3'h1);
            end else begin
                dwell_r <= dwell_r + 24'h000001;
            end
            if (sample_now) begin
                chk_r <= 1'b1;
                col_r <= 3'h0;
            end else if (chk_r) begin
                col_r <= col_r + 3'h1;
                if (col_r == `KME_COL_LAST) begin
                    chk_r <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-key debounce: counts scans read closed, cleared on any open reading
    reg  [5:0] deb_r [0:63];
    genvar g;
    generate
        for (g = 0; g < 64; g = g + 1) begin : g_deb
            always @(posedge clk_sys) begin
                if (reset) begin
                    deb_r[g] <= 6'h00;
                end else if (sample_now && (row_r == g / `KME_ROWS)) begin
                    if (col_s2_r[g % `KME_ROWS]) begin
                        deb_r[g] <= 6'h00;
                    end else if (deb_r[g] != DEB_SCANS) begin
                        deb_r[g] <= deb_r[g] + 6'h01;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // lockout and typematic
    wire [5:0] cur_key;
    wire       cur_pressed;
    reg        lock_v_r;
    reg  [5:0] lock_key_r;
    reg  [9:0] rep_cnt_r;
    reg        rep_first_r;
    reg        rep_pend_r;
    wire       fifo_in_ready;
    wire       new_push;
    wire       rep_push;
    wire       push;
    wire [5:0] push_data;
    wire [9:0] rep_limit;

    assign cur_key     = {row_r, col_r};
    assign cur_pressed = (deb_r[cur_key] == DEB_SCANS);
    assign new_push    = chk_r & ~lock_v_r & cur_pressed & fifo_in_ready;
    assign rep_push    = lock_v_r & rep_pend_r & fifo_in_ready;
    assign push        = new_push | rep_push;
    assign push_data   = lock_v_r ? lock_key_r : cur_key;
    assign rep_limit   = rep_first_r ? TYPE_MS : REP_MS;

    always @(posedge clk_sys) begin
        if (reset) begin
            lock_v_r    <= 1'b0;
            lock_key_r  <= 6'h00;
            rep_cnt_r   <= 10'h000;
            rep_first_r <= 1'b1;
            rep_pend_r  <= 1'b0;
        end else if (new_push) begin
            lock_v_r    <= 1'b1;
            lock_key_r  <= cur_key;
            rep_cnt_r   <= 10'h000;
            rep_first_r <= 1'b1;
            rep_pend_r  <= 1'b0;
        end else if (lock_v_r && chk_r && (cur_key == lock_key_r) && !cur_pressed) begin
            lock_v_r   <= 1'b0;
            rep_pend_r <= 1'b0;
        end else if (lock_v_r) begin
            if (rep_push) begin
                rep_pend_r <= 1'b0;
            end
            if (ms_tick) begin
                if (rep_cnt_r == rep_limit - 10'h001) begin
                    rep_cnt_r   <= 10'h000;
                    rep_first_r <= 1'b0;
                    rep_pend_r  <= 1'b1;
                end else begin
                    rep_cnt_r <= rep_cnt_r + 10'h001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output queue
    wire       q_valid;
    wire [5:0] q_data;
    reg  [4:0] state_r;

    kme_fifo #(
        .WIDTH (`KME_CODE_W),
        .DEPTH (`KME_FIFO_DEPTH),
        .AW    (2)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data),
        .out_valid (q_valid),
        .out_ready (state_r == ST_IDLE),
        .out_data  (q_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // announce, serial frame, hold
    reg [23:0] timer_r;
    reg [9:0]  shift_r;
    reg [3:0]  bit_r;

    always @(posedge clk_sys) begin
        if (reset) begin
            state_r               <= ST_IDLE;
            timer_r               <= 24'h000000;
            shift_r               <= 10'h3FF;
            bit_r                 <= 4'h0;
            serial_tx             <= `KME_LINE_IDLE;
            key_int_n             <= `KME_LINE_IDLE;
            led_on                <= 1'b0;
            key_code_parallel_out <= `KME_CODE_RST;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (q_valid) begin
                        key_code_parallel_out <= q_data;
                        shift_r <= {1'b1, 2'b00, q_data, 1'b0};
                        state_r <= ST_PREP;
                    end
                end
                ST_PREP: begin
                    key_int_n <= 1'b0;
                    led_on    <= 1'b1;
                    timer_r   <= 24'h000000;
                    state_r   <= ST_LEAD;
                end
                ST_LEAD: begin
                    if (timer_r == LEAD_CYCLES - 24'h000001) begin
                        timer_r   <= 24'h000000;
                        serial_tx <= shift_r[0];
                        shift_r   <= {1'b1, shift_r[9:1]};
                        bit_r     <= 4'h1;
                        state_r   <= ST_SEND;
                    end else begin
                        timer_r <= timer_r + 24'h000001;
                    end
                end
                ST_SEND: begin
                    if (timer_r == BAUD_CYCLES - 24'h000001) begin
                        timer_r <= 24'h000000;
                        if (bit_r == `KME_FRAME_BITS) begin
                            state_r <= ST_HOLD;
                        end else begin
                            serial_tx <= shift_r[0];
                            shift_r   <= {1'b1, shift_r[9:1]};
                            bit_r     <= bit_r + 4'h1;
                        end
                    end else begin
                        timer_r <= timer_r + 24'h000001;
                    end
                end
                ST_HOLD: begin
                    if (timer_r == INT_CYCLES - 24'h000001) begin
                        key_int_n <= `KME_LINE_IDLE;
                        led_on    <= 1'b0;
                        state_r   <= ST_IDLE;
                    end else begin
                        timer_r <= timer_r + 24'h000001;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // kme_encoder
